// *** cmp_ctrl_defines.vh ***
// Register offsets, bit positions and reset values for the comparator control block.
`ifndef CMP_CTRL_DEFINES_VH
`define CMP_CTRL_DEFINES_VH
`define ADDR_CMP_ONE_CTRL 2'h0
`define ADDR_CMP_TWO_CTRL 2'h1
`define ADDR_CMP_SHARED_CTRL 2'h2
`define ADDR_PORT_READ 2'h3
`define BIT_CTRL_ON 7
`define BIT_CTRL_OUT 6
`define BIT_CTRL_NONINV_SEL 2
`define BIT_MIRROR_ONE 7
`define BIT_MIRROR_TWO 6
`define BIT_REF_ONE 5
`define BIT_REF_TWO 4
`define BIT_HYS_ONE 3
`define BIT_HYS_TWO 2
`define BIT_SYNC_ONE 1
`define BIT_SYNC_TWO 0
`define CTRL_WR_MASK 8'hbf
`define SHARED_WR_MASK 8'h3f
`define BYTE_ZERO 8'h00
`define BIT_CLEAR 1'h0
`define SHARED_CFG_MSB 5
`define SHARED_CFG_LSB 0
`define PORT_BYTE_MSB 7
`define PORT_BYTE_LSB 0
`endif

// *** comparator_output_control.v ***
// Digital control of two comparators: registers, reference routing, output sync, port read.
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
`include "cmp_ctrl_defines.vh"

module comparator_output_control #(
    parameter PORT_W = 8
) (
    // Clock and reset
    input wire core_clk,
    input wire resetn,
    // Register port
    input wire [1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Analog comparator raw outputs (already polarity-applied)
    input wire cmp_one_raw,
    input wire cmp_two_raw,
    // Prescaled timer clock edge pulse, same pulse that increments the counter
    input wire timer_one_tick,
    // Port pins and analog selection
    input wire [PORT_W-1:0] port_pins,
    input wire [PORT_W-1:0] analog_sel,
    // Comparator outputs after optional synchronisation
    output reg cmp_one_output_bit,
    output reg cmp_two_output_bit,
    // Analog steering
    output reg cmp_one_ref_choice,
    output reg cmp_two_ref_choice,
    output reg cmp_one_hysteresis_en,
    output reg cmp_two_hysteresis_en,
    output reg cmp_one_ref_to_input,
    output reg cmp_two_ref_to_input,
    // Mismatch latch clear pulses
    output reg cmp_one_mismatch_clr,
    output reg cmp_two_mismatch_clr
);

// ------------------------------------------------------------
// Register storage and internal nets
// ------------------------------------------------------------
reg [7:0] cmp_one_control_r;
reg [7:0] cmp_one_control_nxt;
reg [7:0] cmp_two_control_r;
reg [7:0] cmp_two_control_nxt;
reg [7:0] shared_ctrl_r;
reg [7:0] shared_ctrl_nxt;
reg sync_one_r;
reg sync_one_nxt;
reg sync_two_r;
reg sync_two_nxt;
reg [7:0] rdata_nxt;
reg [7:0] reg_rdata_nxt;
reg cmp_one_mismatch_clr_nxt;
reg cmp_two_mismatch_clr_nxt;
wire out_one_nxt;
wire out_two_nxt;
wire [7:0] shared_view;
wire [7:0] port_view;
wire wr_one_hit;
wire wr_two_hit;
wire wr_shared_hit;
wire acc_one_hit;
wire acc_two_hit;

// ------------------------------------------------------------
// Helper functions
// ------------------------------------------------------------
// Read-modify-write merge: bits outside the mask keep their stored value.
function [7:0] merge_wr;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] mask;
    begin
        merge_wr = (old_val & ~mask) | (new_val & mask);
    end
endfunction

// True when the strobe is high and the index selects the given register.
function addr_hit;
    input strobe;
    input [1:0] addr;
    input [1:0] target;
    begin
        addr_hit = strobe && (addr == target);
    end
endfunction

// Takes the latched copy in synchronous mode and the live level otherwise.
function pick_output;
    input sync_mode;
    input latched;
    input live;
    begin
        pick_output = sync_mode ? latched : live;
    end
endfunction

// Control register view: the selected output takes the place of the stored bit.
function [7:0] ctrl_view;
    input [7:0] stored;
    input live_out;
    begin
        ctrl_view = stored;
        ctrl_view[`BIT_CTRL_OUT] = live_out;
    end
endfunction

// ------------------------------------------------------------
// Access decode
// ------------------------------------------------------------
assign wr_one_hit = addr_hit(reg_wr, reg_addr, `ADDR_CMP_ONE_CTRL);
assign wr_two_hit = addr_hit(reg_wr, reg_addr, `ADDR_CMP_TWO_CTRL);
assign wr_shared_hit = addr_hit(reg_wr, reg_addr, `ADDR_CMP_SHARED_CTRL);
// Every write starts with a read, so both strobes count as a control access.
assign acc_one_hit = addr_hit(reg_wr || reg_rd, reg_addr, `ADDR_CMP_ONE_CTRL);
assign acc_two_hit = addr_hit(reg_wr || reg_rd, reg_addr, `ADDR_CMP_TWO_CTRL);

// ------------------------------------------------------------
// Output synchronisation latches
// ------------------------------------------------------------
// The tick is the prescaled timer edge that also advances the counter, so the
// latch and the count move on one edge and cannot race each other.
always @* begin
    sync_one_nxt = sync_one_r;
    sync_two_nxt = sync_two_r;
    if (timer_one_tick) begin
        sync_one_nxt = cmp_one_raw;
        sync_two_nxt = cmp_two_raw;
    end
end

always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        sync_one_r <= `BIT_CLEAR;
        sync_two_r <= `BIT_CLEAR;
    end else begin
        sync_one_r <= sync_one_nxt;
        sync_two_r <= sync_two_nxt;
    end
end

// ------------------------------------------------------------
// Output selection
// ------------------------------------------------------------
// With the sync bit clear the live level passes straight through.
assign out_one_nxt = pick_output(shared_ctrl_r[`BIT_SYNC_ONE], sync_one_r,
    cmp_one_raw);
assign out_two_nxt = pick_output(shared_ctrl_r[`BIT_SYNC_TWO], sync_two_r,
    cmp_two_raw);

// ------------------------------------------------------------
// Control register next values
// ------------------------------------------------------------
// The output bit of a control register is a live copy and is never stored.
always @* begin
    cmp_one_control_nxt = cmp_one_control_r;
    if (wr_one_hit) begin
        cmp_one_control_nxt = merge_wr(cmp_one_control_r, reg_wdata, `CTRL_WR_MASK);
    end
end

always @* begin
    cmp_two_control_nxt = cmp_two_control_r;
    if (wr_two_hit) begin
        cmp_two_control_nxt = merge_wr(cmp_two_control_r, reg_wdata, `CTRL_WR_MASK);
    end
end

// Writes into the mirror positions are masked off here.
always @* begin
    shared_ctrl_nxt = shared_ctrl_r;
    if (wr_shared_hit) begin
        shared_ctrl_nxt = merge_wr(shared_ctrl_r, reg_wdata, `SHARED_WR_MASK);
    end
end

// ------------------------------------------------------------
// Control register flip-flops
// ------------------------------------------------------------
always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        cmp_one_control_r <= `BYTE_ZERO;
        cmp_two_control_r <= `BYTE_ZERO;
        shared_ctrl_r <= `BYTE_ZERO;
    end else begin
        cmp_one_control_r <= cmp_one_control_nxt;
        cmp_two_control_r <= cmp_two_control_nxt;
        shared_ctrl_r <= shared_ctrl_nxt;
    end
end

// ------------------------------------------------------------
// Read path
// ------------------------------------------------------------
// The mirror bits are rebuilt from the selected outputs on every read, so both
// comparators are seen in one access without skew.
assign shared_view = {out_one_nxt, out_two_nxt,
    shared_ctrl_r[`SHARED_CFG_MSB:`SHARED_CFG_LSB]};
// Pins set to analog read as zero whatever level they carry.
assign port_view = port_pins[`PORT_BYTE_MSB:`PORT_BYTE_LSB]
    & ~analog_sel[`PORT_BYTE_MSB:`PORT_BYTE_LSB];

always @* begin
    case (reg_addr)
        `ADDR_CMP_ONE_CTRL: begin
            rdata_nxt = ctrl_view(cmp_one_control_r, out_one_nxt);
        end
        `ADDR_CMP_TWO_CTRL: begin
            rdata_nxt = ctrl_view(cmp_two_control_r, out_two_nxt);
        end
        `ADDR_CMP_SHARED_CTRL: begin
            rdata_nxt = shared_view;
        end
        `ADDR_PORT_READ: begin
            rdata_nxt = port_view;
        end
        default: begin
            rdata_nxt = `BYTE_ZERO;
        end
    endcase
end

// Read data stand only in the cycle after the strobe and are zero otherwise.
always @* begin
    reg_rdata_nxt = `BYTE_ZERO;
    if (reg_rd) begin
        reg_rdata_nxt = rdata_nxt;
    end
end

always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        reg_rdata <= `BYTE_ZERO;
    end else begin
        reg_rdata <= reg_rdata_nxt;
    end
end

// ------------------------------------------------------------
// Mismatch latch clear pulses
// ------------------------------------------------------------
// Only control register accesses disturb the mismatch latches; shared register
// and port reads never do.
always @* begin
    cmp_one_mismatch_clr_nxt = acc_one_hit;
    cmp_two_mismatch_clr_nxt = acc_two_hit;
end

always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        cmp_one_mismatch_clr <= `BIT_CLEAR;
        cmp_two_mismatch_clr <= `BIT_CLEAR;
    end else begin
        cmp_one_mismatch_clr <= cmp_one_mismatch_clr_nxt;
        cmp_two_mismatch_clr <= cmp_two_mismatch_clr_nxt;
    end
end

// ------------------------------------------------------------
// Comparator output flip-flops
// ------------------------------------------------------------
always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        cmp_one_output_bit <= `BIT_CLEAR;
        cmp_two_output_bit <= `BIT_CLEAR;
    end else begin
        cmp_one_output_bit <= out_one_nxt;
        cmp_two_output_bit <= out_two_nxt;
    end
end

// ------------------------------------------------------------
// Analog steering
// ------------------------------------------------------------
// A set reference choice selects the fixed reference, a clear one the programmable.
always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        cmp_one_ref_choice <= `BIT_CLEAR;
        cmp_two_ref_choice <= `BIT_CLEAR;
        cmp_one_hysteresis_en <= `BIT_CLEAR;
        cmp_two_hysteresis_en <= `BIT_CLEAR;
    end else begin
        cmp_one_ref_choice <= shared_ctrl_r[`BIT_REF_ONE];
        cmp_two_ref_choice <= shared_ctrl_r[`BIT_REF_TWO];
        cmp_one_hysteresis_en <= shared_ctrl_r[`BIT_HYS_ONE];
        cmp_two_hysteresis_en <= shared_ctrl_r[`BIT_HYS_TWO];
    end
end

// A set control bit sends the internal reference node to the input, else the pin.
always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
        cmp_one_ref_to_input <= `BIT_CLEAR;
        cmp_two_ref_to_input <= `BIT_CLEAR;
    end else begin
        cmp_one_ref_to_input <= cmp_one_control_r[`BIT_CTRL_NONINV_SEL];
        cmp_two_ref_to_input <= cmp_two_control_r[`BIT_CTRL_NONINV_SEL];
    end
end

endmodule // comparator_output_control

// *** cmp_ctrl_properties.sv ***
// Port-level assertions for the comparator control block.
`timescale 1ns/100ps
module cmp_ctrl_checker #(parameter PORT_W = 8) (
    // All watched ports.
    input wire core_clk, resetn, reg_wr, reg_rd, cmp_one_raw, timer_one_tick,
    input wire [1:0] reg_addr,
    input wire [7:0] reg_wdata, reg_rdata,
    input wire [PORT_W-1:0] port_pins, analog_sel,
    input wire cmp_one_output_bit, cmp_one_ref_choice, cmp_two_ref_choice,
    input wire cmp_one_hysteresis_en, cmp_two_hysteresis_en,
    input wire cmp_one_mismatch_clr, cmp_two_mismatch_clr
);
    reg [7:0] sh_r;
    always @(posedge core_clk or negedge resetn)
        if (!resetn) sh_r <= 8'h00;
        else if (reg_wr && reg_addr == 2'h2) sh_r <= reg_wdata;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    one_async_a: assert property (
        $past(resetn) && !$past(sh_r[1]) |-> cmp_one_output_bit == $past(cmp_one_raw))
        else $error("direct output wrong");
    one_hold_a: assert property (
        $past(sh_r[1] & ~timer_one_tick) && $past(sh_r[1] & ~timer_one_tick, 2)
        && !timer_one_tick |-> $stable(cmp_one_output_bit)) else $error("latch moved");
    ref_pair_a: assert property (
        $past(resetn) |-> {cmp_one_ref_choice, cmp_two_ref_choice} == $past(sh_r[5:4]))
        else $error("ref choice wrong");
    hys_pair_a: assert property (
        $past(resetn) |-> {cmp_one_hysteresis_en, cmp_two_hysteresis_en} == $past(sh_r[3:2]))
        else $error("hysteresis wrong");
    clr_access_a: assert property (
        (reg_wr || reg_rd) && reg_addr != 2'h3 |=> {cmp_one_mismatch_clr, cmp_two_mismatch_clr}
        == {$past(reg_addr) == 2'h0, $past(reg_addr) == 2'h1}) else $error("clear wrong");
    clr_idle_a: assert property (
        !reg_wr && !reg_rd |=> !cmp_one_mismatch_clr && !cmp_two_mismatch_clr)
        else $error("stray clear");
    port_read_a: assert property (
        reg_rd && reg_addr == 2'h3 |=> reg_rdata == $past(port_pins & ~analog_sel))
        else $error("port read wrong");
    shared_read_a: assert property (
        reg_rd && reg_addr == 2'h2 |=> reg_rdata[5:0] == $past(sh_r[5:0]))
        else $error("shared read wrong");
    cover property (reg_wr && reg_addr == 2'h0);
    cover property (reg_rd && reg_addr == 2'h3);
    cover property (timer_one_tick && sh_r[1]);
endmodule // cmp_ctrl_checker
bind comparator_output_control cmp_ctrl_checker #(.PORT_W(PORT_W)) chk (.*);

// *** timer_cmp_model.sv ***
// Timer edge source and comparator stand-in for the block's far side.
`timescale 1ns/100ps
module timer_cmp_model (
    // Clock, reset and requested comparator levels.
    input wire core_clk, resetn,
    input wire [1:0] cmp_lvl,
    // Far-side outputs.
    output reg timer_one_tick,
    output wire cmp_one_raw, cmp_two_raw
);
    reg [3:0] div_r;
    assign {cmp_one_raw, cmp_two_raw} = cmp_lvl;
    // The same prescaled pulse both latches the outputs and steps the counter.
    always @(posedge core_clk or negedge resetn)
        if (!resetn) begin
            div_r <= 4'h0;
            timer_one_tick <= 1'b0;
        end else begin
            div_r <= div_r + 4'h1;
            timer_one_tick <= div_r == 4'hf;
        end
endmodule // timer_cmp_model

// *** tb_top.sv ***
// Self-checking bench for the comparator control block.
`timescale 1ns/100ps
module tb_top;
    reg core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
    reg [1:0] reg_addr = 0, cmp_lvl = 0;
    reg [7:0] reg_wdata = 0, port_pins = 0, analog_sel = 0;
    wire [7:0] reg_rdata;
    wire cmp_one_raw, cmp_two_raw, timer_one_tick, cmp_one_output_bit, cmp_two_output_bit;
    wire cmp_one_ref_choice, cmp_two_ref_choice, cmp_one_hysteresis_en, cmp_two_hysteresis_en;
    wire cmp_one_ref_to_input, cmp_two_ref_to_input, cmp_one_mismatch_clr, cmp_two_mismatch_clr;
    wire [7:0] outs = {cmp_one_output_bit, cmp_two_output_bit, cmp_one_ref_choice,
        cmp_two_ref_choice, cmp_one_hysteresis_en, cmp_two_hysteresis_en,
        cmp_one_ref_to_input, cmp_two_ref_to_input};
    integer err_count = 0, comparisons = 0;
    timer_cmp_model far (.*);
    comparator_output_control uut (.*);
    task chk(input [47:0] n, input [7:0] e, input [7:0] s);
        begin
            comparisons = comparisons + 1;
            if (s !== e) begin
                err_count = err_count + 1;
                $display("BAD %0s exp %h got %h", n, e, s);
            end
        end
    endtask
    task wr(input [1:0] a, input [7:0] d);
        begin
            @(posedge core_clk);
            reg_wr <= 1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge core_clk);
            reg_wr <= 0;
        end
    endtask
    task rd(input [1:0] a, input [7:0] e);
        begin
            @(posedge core_clk);
            reg_rd <= 1;
            reg_addr <= a;
            @(posedge core_clk);
            reg_rd <= 0;
            #1 chk("rdata", e, reg_rdata);
        end
    endtask
    task complete_run;
        begin
            $display("errors %0d comparisons %0d", err_count, comparisons);
            if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial forever #4 core_clk = ~core_clk;
    initial begin
        #20000 err_count = err_count + 1;
        complete_run;
    end
    task check_reset_state;
        begin
            rd(2'h2, 8'h00);
            chk("outs", 8'h00, outs);
        end
    endtask
    task check_shared_bits;
        begin
            wr(2'h2, 8'hff);
            rd(2'h2, 8'h3f);
            chk("outs", 8'h3c, outs);
        end
    endtask
    task check_direct_path;
        begin
            wr(2'h2, 8'h00);
            cmp_lvl <= 2'h3;
            rd(2'h2, 8'hc0);
            chk("direct", 8'hc0, outs & 8'hc0);
        end
    endtask
    task check_sync_latch;
        begin
            wr(2'h2, 8'h03);
            @(posedge timer_one_tick);
            repeat (4) @(posedge core_clk);
            cmp_lvl <= 2'h0;
            repeat (4) @(posedge core_clk);
            #1 chk("held", 8'hc0, outs & 8'hc0);
            @(posedge timer_one_tick);
            repeat (3) @(posedge core_clk);
            #1 chk("synced", 8'h00, outs & 8'hc0);
            rd(2'h2, 8'h03);
        end
    endtask
    task check_ctrl_regs;
        begin
            wr(2'h0, 8'hff);
            rd(2'h0, 8'hbf);
            wr(2'h1, 8'h04);
            rd(2'h1, 8'h04);
            chk("route", 8'h03, outs & 8'h03);
        end
    endtask
    task check_port_read;
        begin
            @(posedge core_clk);
            port_pins <= 8'hff;
            analog_sel <= 8'h0f;
            rd(2'h3, 8'hf0);
            wr(2'h3, 8'h00);
            rd(2'h3, 8'hf0);
        end
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        resetn <= 1;
        check_reset_state;
        check_shared_bits;
        check_direct_path;
        check_sync_latch;
        check_ctrl_regs;
        check_port_read;
        complete_run;
    end
endmodule // tb_top
